//--- pbb_panel.sv
// Speaker and power LED model that counts rising edges it receives.
`timescale 1ns/1ps
module pbb_panel (
   input  wire logic clk,
   input  wire logic clear,
   input  wire logic spk,
   input  wire logic led,
   output int        spk_rises,
   output int        led_rises
);
   logic spk_q; // Speaker level one cycle ago.
   logic led_q; // LED level one cycle ago.

   // Only clean 0 to 1 steps count, so an unknown never adds a rise.
   always_ff @(posedge clk) begin
      spk_q <= spk;
      led_q <= led;
      if (clear) begin
         spk_rises <= 0;
         led_rises <= 0;
      end else begin
         spk_rises <= spk_rises + int'(spk === 1'b1 && spk_q === 1'b0);
         led_rises <= led_rises + int'(led === 1'b1 && led_q === 1'b0);
      end
   end
endmodule

//--- pbb_params.svh
// Timing constants for the indicator sequencer.
`ifndef PBB_PARAMS_SVH
`define PBB_PARAMS_SVH

// System clock rate in hertz.
`define PBB_CLK_HZ 50000000

// Base time slot of every pattern, in milliseconds, and in clock cycles.
`define PBB_QUARTER_MS 250
`define PBB_QUARTER_CYC ((`PBB_CLK_HZ / 1000) * `PBB_QUARTER_MS)

// Tone frequencies in hertz.
`define PBB_BEEP_HZ 932
`define PBB_LOW_HZ 1500
`define PBB_HIGH_HZ 2000

// Half periods of each tone, in clock cycles.
`define PBB_BEEP_HALF_CYC (`PBB_CLK_HZ / (2 * `PBB_BEEP_HZ))
`define PBB_LOW_HALF_CYC (`PBB_CLK_HZ / (2 * `PBB_LOW_HZ))
`define PBB_HIGH_HALF_CYC (`PBB_CLK_HZ / (2 * `PBB_HIGH_HZ))

// Pattern durations, counted in 0.25 s slots.
`define PBB_PROMPT_Q 2
`define PBB_BEAT_Q 4
`define PBB_PAUSE_Q 10
`define PBB_UPD_Q 2

// Repetition counts.
`define PBB_VID_BEEPS 2
`define PBB_MEM_BEEPS 3
`define PBB_VID_GROUPS 2
`define PBB_THERM_TONES 8

// Bit positions of the condition inputs in the synchroniser vector.
`define PBB_IN_PROMPT 0
`define PBB_IN_UPDATE 1
`define PBB_IN_VIDEO 2
`define PBB_IN_MEMORY 3
`define PBB_IN_THERM 4
`define PBB_IN_COUNT 5

`endif

//--- pbb_pkg.sv
// Types shared by the indicator sequencer and its time base.
package pbb_pkg;

   // Tone requested from the time base.
   typedef enum logic [1:0] {
      PBB_TONE_OFF,
      PBB_TONE_BEEP,
      PBB_TONE_LOW,
      PBB_TONE_HIGH
   } pbb_tone_t;

   // Indication being shown.
   typedef enum logic [2:0] {
      PBB_ST_IDLE,
      PBB_ST_PROMPT,
      PBB_ST_UPDATE,
      PBB_ST_VIDEO,
      PBB_ST_MEMORY,
      PBB_ST_THERMAL,
      PBB_ST_SHUTDOWN
   } pbb_state_t;

endpackage

//--- pbb_seq.sv
// Beep and blink sequencer for board condition indications.
//
// Overview of operation
// - Prompt gives one 0.5 s 932 Hz beep.
// - Video: two beeps, pause, group twice, silent.
// - Video: LED two blinks, pause, repeats forever.
// - Video error requested when video ROM missing.
// - Memory: three beeps, pause, repeats forever.
// - Memory: LED three blinks, pause, forever.
// - Thermal: eight alternating tones, then shutdown request.
// - Thermal: LED blinks 0.25 s, twice each tone.
// - Update: silent, LED off, then 0.5 s blinking.
`timescale 1ns/1ps
`include "pbb_params.svh"
module pbb_seq #(
   parameter int unsigned QUARTER_CYC   = `PBB_QUARTER_CYC,
   parameter int unsigned BEEP_HALF_CYC = `PBB_BEEP_HALF_CYC,
   parameter int unsigned LOW_HALF_CYC  = `PBB_LOW_HALF_CYC,
   parameter int unsigned HIGH_HALF_CYC = `PBB_HIGH_HALF_CYC
) (
   input  wire logic CLOCK,
   input  wire logic RST,
   input  wire logic PROMPT,
   input  wire logic UPDATE,
   input  wire logic VIDEO_ERR,
   input  wire logic MEM_ERR,
   input  wire logic THERM_WARN,
   output logic      SPEAKER,
   output logic      LED,
   output logic      SHUTDOWN_REQ
);

   // Slot counts held at the width of the position counter.
   localparam logic [5:0] BEAT    = 6'(`PBB_BEAT_Q);
   localparam logic [5:0] PRM_LEN = 6'(`PBB_PROMPT_Q);
   localparam logic [5:0] UPD_LEN = 6'(`PBB_UPD_Q);
   localparam logic [5:0] VID_ON  = 6'(2 * `PBB_VID_BEEPS * `PBB_BEAT_Q);
   localparam logic [5:0] MEM_ON  = 6'(2 * `PBB_MEM_BEEPS * `PBB_BEAT_Q);
   localparam logic [5:0] VID_LEN = 6'(2 * `PBB_VID_BEEPS * `PBB_BEAT_Q
                                       + `PBB_PAUSE_Q);
   localparam logic [5:0] MEM_LEN = 6'(2 * `PBB_MEM_BEEPS * `PBB_BEAT_Q
                                       + `PBB_PAUSE_Q);
   localparam logic [5:0] THM_LEN = 6'(`PBB_THERM_TONES * `PBB_BEAT_Q);
   localparam logic [1:0] VID_GRP = 2'(`PBB_VID_GROUPS);

   pbb_tick_if tick ();                     // Link to the time base.

   logic [`PBB_IN_COUNT-1:0] pin_in;        // Raw condition pins.
   logic [`PBB_IN_COUNT-1:0] sync1;         // First synchroniser stage.
   logic [`PBB_IN_COUNT-1:0] sync2;         // Second synchroniser stage.
   logic [`PBB_IN_COUNT-1:0] sync3;         // Third synchroniser stage.
   logic [`PBB_IN_COUNT-1:0] cond;          // Accepted condition levels.
   pbb_pkg::pbb_state_t      state;         // Indication now shown.
   pbb_pkg::pbb_state_t      want_state;    // Highest-priority request.
   pbb_pkg::pbb_state_t      next_state;    // State for the next cycle.
   logic [5:0]               pos;           // Slot within the group.
   logic [1:0]               grp;           // Completed groups, saturating.
   logic [5:0]               grp_len;       // Slots in one group.
   wire                      grp_end;       // Last slot of a group ends.
   wire                      beat_on;       // First half of a 2.0 s beat.
   pbb_pkg::pbb_tone_t       next_tone;     // Tone for the speaker.
   wire                      next_led;      // LED level to register.

   assign pin_in = {THERM_WARN, MEM_ERR, VIDEO_ERR, UPDATE, PROMPT};

   // Time base for slots and tones, counted from the system clock.
   pbb_timebase #(
      .QUARTER_CYC   (QUARTER_CYC),
      .BEEP_HALF_CYC (BEEP_HALF_CYC),
      .LOW_HALF_CYC  (LOW_HALF_CYC),
      .HIGH_HALF_CYC (HIGH_HALF_CYC)
   ) u_timebase (
      .clk (CLOCK),
      .rst (RST),
      .tb  (tick.gen)
   );

   // Each pin passes three stages; a level is accepted only when the
   // second and third agree, so a single metastable sample never counts.
   genvar i;
   generate
      for (i = 0; i < `PBB_IN_COUNT; i++) begin : g_sync
         always_ff @(posedge CLOCK) begin
            if (RST) begin
               sync1[i] <= 1'b0;
               sync2[i] <= 1'b0;
               sync3[i] <= 1'b0;
               cond[i]  <= 1'b0;
            end else begin
               sync1[i] <= pin_in[i];
               sync2[i] <= sync1[i];
               sync3[i] <= sync2[i];
               if (sync2[i] == sync3[i]) begin
                  cond[i] <= sync3[i];
               end
            end
         end
      end
   endgenerate

   // Priority among requests: thermal, memory, video, update, prompt.
   // The video request is raised by firmware when no video ROM is found.
   assign want_state =
      cond[`PBB_IN_THERM]  ? pbb_pkg::PBB_ST_THERMAL :
      cond[`PBB_IN_MEMORY] ? pbb_pkg::PBB_ST_MEMORY :
      cond[`PBB_IN_VIDEO]  ? pbb_pkg::PBB_ST_VIDEO :
      cond[`PBB_IN_UPDATE] ? pbb_pkg::PBB_ST_UPDATE :
      cond[`PBB_IN_PROMPT] ? pbb_pkg::PBB_ST_PROMPT :
                             pbb_pkg::PBB_ST_IDLE;

   // Group length of the current indication, in slots.
   assign grp_len =
      (state == pbb_pkg::PBB_ST_PROMPT)  ? PRM_LEN :
      (state == pbb_pkg::PBB_ST_UPDATE)  ? 6'(2 * UPD_LEN) :
      (state == pbb_pkg::PBB_ST_VIDEO)   ? VID_LEN :
      (state == pbb_pkg::PBB_ST_MEMORY)  ? MEM_LEN :
      (state == pbb_pkg::PBB_ST_THERMAL) ? THM_LEN :
                                           6'h01;
   assign grp_end = tick.quarter && (pos == grp_len - 6'h01);

   // Error indications latch until RST, since the firmware
   // may halt and stop driving them; only a higher priority preempts.
   assign next_state =
      (state == pbb_pkg::PBB_ST_THERMAL && grp_end) ?
         pbb_pkg::PBB_ST_SHUTDOWN :
      (state == pbb_pkg::PBB_ST_THERMAL ||
       state == pbb_pkg::PBB_ST_SHUTDOWN) ? state :
      cond[`PBB_IN_THERM] ? pbb_pkg::PBB_ST_THERMAL :
      (state == pbb_pkg::PBB_ST_MEMORY) ? state :
      cond[`PBB_IN_MEMORY] ? pbb_pkg::PBB_ST_MEMORY :
      (state == pbb_pkg::PBB_ST_VIDEO) ? state :
      want_state;

   // A new indication restarts slot and tone phase so its first slot is
   // a full 0.25 s long.
   assign tick.restart = (next_state != state);

   // First half of each 2.0 s beat is the on half.
   assign beat_on = ((pos % (6'h02 * BEAT)) < BEAT);

   // Speaker tone for the current slot.
   assign next_tone =
      (state == pbb_pkg::PBB_ST_PROMPT && grp == 2'h0) ?
         pbb_pkg::PBB_TONE_BEEP :
      (state == pbb_pkg::PBB_ST_VIDEO && grp < VID_GRP &&
       pos < VID_ON && beat_on) ?
         pbb_pkg::PBB_TONE_BEEP :
      (state == pbb_pkg::PBB_ST_MEMORY && pos < MEM_ON && beat_on) ?
         pbb_pkg::PBB_TONE_BEEP :
      (state == pbb_pkg::PBB_ST_THERMAL) ?
         (beat_on ? pbb_pkg::PBB_TONE_HIGH
                  : pbb_pkg::PBB_TONE_LOW) :
         pbb_pkg::PBB_TONE_OFF;
   assign tick.tone_sel = next_tone;

   // LED level for the current slot; prompt and idle leave it dark.
   assign next_led =
      (state == pbb_pkg::PBB_ST_VIDEO)   ? (pos < VID_ON && beat_on) :
      (state == pbb_pkg::PBB_ST_MEMORY)  ? (pos < MEM_ON && beat_on) :
      (state == pbb_pkg::PBB_ST_THERMAL) ? !pos[0] :
      (state == pbb_pkg::PBB_ST_UPDATE)  ? (pos >= UPD_LEN) :
                                           1'b0;

   // State register.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         state <= pbb_pkg::PBB_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Slot position within the group and the count of finished groups.
   always_ff @(posedge CLOCK) begin
      if (RST || tick.restart) begin
         pos <= 6'h00;
         grp <= 2'h0;
      end else if (grp_end) begin
         pos <= 6'h00;
         // Saturates, because the video beeps only need to know "two".
         if (grp != 2'h3) begin
            grp <= grp + 2'h1;
         end
      end else if (tick.quarter) begin
         pos <= pos + 6'h01;
      end
   end

   // Output flops; the speaker lags the tone wave by one cycle.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         SPEAKER      <= 1'b0;
         LED          <= 1'b0;
         SHUTDOWN_REQ <= 1'b0;
      end else begin
         SPEAKER      <= tick.wave;
         LED          <= next_led;
         SHUTDOWN_REQ <= (state == pbb_pkg::PBB_ST_SHUTDOWN);
      end
   end

endmodule

//--- pbb_seq_props.sv
// Concurrent checks on the pins of the indicator sequencer.
`timescale 1ns/1ps
module pbb_seq_props (
   input wire logic CLOCK,
   input wire logic RST,
   input wire logic PROMPT,
   input wire logic UPDATE,
   input wire logic VIDEO_ERR,
   input wire logic MEM_ERR,
   input wire logic THERM_WARN,
   input wire logic SPEAKER,
   input wire logic LED,
   input wire logic SHUTDOWN_REQ
);
   logic err_seen;   // Some error pin was high since reset.
   logic therm_seen; // The thermal pin was high since reset.
   wire  any_pin = PROMPT | UPDATE | VIDEO_ERR | MEM_ERR | THERM_WARN;

   // Error indications outlive their pins, so the pins are remembered.
   always_ff @(posedge CLOCK) begin
      if (RST) begin
         err_seen   <= 1'b0;
         therm_seen <= 1'b0;
      end else begin
         err_seen   <= err_seen | VIDEO_ERR | MEM_ERR | THERM_WARN;
         therm_seen <= therm_seen | THERM_WARN;
      end
   end

   default clocking dck @(posedge CLOCK); endclocking
   default disable iff (RST);

   // Eight quiet cycles cover the pin synchroniser and output lag.
   sequence s_calm; !any_pin && !err_seen; endsequence
   sequence s_upd; UPDATE && !err_seen; endsequence
   sequence s_prm; PROMPT && !UPDATE && !err_seen; endsequence

   a_idle_quiet: assert property (s_calm [*8] |-> !SPEAKER && !LED)
      else $error("speaker or led active while idle");
   a_update_silent: assert property (s_upd [*8] |-> !SPEAKER)
      else $error("speaker sounds during update");
   a_prompt_dark: assert property (s_prm [*8] |-> !LED)
      else $error("led lit during prompt");
   a_shut_hold: assert property (SHUTDOWN_REQ |=> SHUTDOWN_REQ)
      else $error("shutdown request dropped");
   a_shut_cause: assert property (
      $rose(SHUTDOWN_REQ) |-> therm_seen)
      else $error("shutdown request without thermal warning");
   a_shut_quiet: assert property (SHUTDOWN_REQ |-> !SPEAKER && !LED)
      else $error("outputs active after shutdown request");
   a_led_slot: assert property ($rose(LED) |=> LED [*8])
      else $error("led pulse shorter than a slot");
   a_spk_half: assert property (
      $changed(SPEAKER) |=> $stable(SPEAKER) [*2])
      else $error("speaker toggles too fast");
endmodule

bind pbb_seq pbb_seq_props chk_u (
   .CLOCK        (CLOCK),
   .RST          (RST),
   .PROMPT       (PROMPT),
   .UPDATE       (UPDATE),
   .VIDEO_ERR    (VIDEO_ERR),
   .MEM_ERR      (MEM_ERR),
   .THERM_WARN   (THERM_WARN),
   .SPEAKER      (SPEAKER),
   .LED          (LED),
   .SHUTDOWN_REQ (SHUTDOWN_REQ)
);

//--- pbb_tick_if.sv
// Carrier between the sequencer and its time base.
`timescale 1ns/1ps
interface pbb_tick_if;

   logic                restart;  // Realigns slot and tone phase.
   pbb_pkg::pbb_tone_t  tone_sel; // Tone to generate.
   logic                quarter;  // One-cycle pulse every 0.25 s.
   logic                wave;     // Square wave of the selected tone.

   modport gen (input restart, input tone_sel, output quarter, output wave);
   modport seq (output restart, output tone_sel, input quarter, input wave);

endinterface

//--- pbb_timebase.sv
// Time base: 0.25 s slot pulse and tone square-wave generator.
`timescale 1ns/1ps
`include "pbb_params.svh"
module pbb_timebase #(
   parameter int unsigned QUARTER_CYC   = `PBB_QUARTER_CYC,
   parameter int unsigned BEEP_HALF_CYC = `PBB_BEEP_HALF_CYC,
   parameter int unsigned LOW_HALF_CYC  = `PBB_LOW_HALF_CYC,
   parameter int unsigned HIGH_HALF_CYC = `PBB_HIGH_HALF_CYC
) (
   input wire logic   clk,
   input wire logic   rst,
   pbb_tick_if.gen    tb
);

   logic [23:0] slot_cnt;  // Cycles into the current slot.
   logic [15:0] tone_cnt;  // Cycles into the current half period.
   logic [15:0] half_last; // Last count of a half period for this tone.
   wire         slot_end;  // Final cycle of a slot.
   wire         tone_on;   // A tone is requested.
   wire         half_end;  // Final cycle of a half period.

   // Selects the half period; a longer tone count can outrun a shorter
   // one after a tone switch, so the end test is "at or past".
   assign half_last =
      (tb.tone_sel == pbb_pkg::PBB_TONE_HIGH) ? 16'(HIGH_HALF_CYC - 1) :
      (tb.tone_sel == pbb_pkg::PBB_TONE_LOW)  ? 16'(LOW_HALF_CYC - 1) :
                                                16'(BEEP_HALF_CYC - 1);
   assign slot_end = (slot_cnt >= 24'(QUARTER_CYC - 1));
   assign tone_on  = (tb.tone_sel != pbb_pkg::PBB_TONE_OFF);
   assign half_end = (tone_cnt >= half_last);

   // Slot counter; every pattern interval is a whole number of slots.
   always_ff @(posedge clk) begin
      if (rst || tb.restart || slot_end) begin
         slot_cnt <= 24'h00_0000;
      end else begin
         slot_cnt <= slot_cnt + 24'h00_0001;
      end
   end

   // Slot pulse, registered so the sequencer sees a clean one-cycle event.
   always_ff @(posedge clk) begin
      if (rst || tb.restart) begin
         tb.quarter <= 1'b0;
      end else begin
         tb.quarter <= slot_end;
      end
   end

   // Half-period counter; held at zero while silent.
   always_ff @(posedge clk) begin
      if (rst || tb.restart || !tone_on || half_end) begin
         tone_cnt <= 16'h0000;
      end else begin
         tone_cnt <= tone_cnt + 16'h0001;
      end
   end

   // Square wave toggles at each half period and rests low when silent.
   always_ff @(posedge clk) begin
      if (rst || tb.restart || !tone_on) begin
         tb.wave <= 1'b0;
      end else if (half_end) begin
         tb.wave <= !tb.wave;
      end
   end

endmodule

//--- tb.sv
// Self-checking bench for the indicator sequencer.
`timescale 1ns/1ps
module tb;
   localparam int LIMIT = 12000; // Run ceiling; the tests need about 5000.
   // One ordinary case: pins {thermal, memory, video, update, prompt}.
   typedef struct {
      logic [4:0] pins;
      int         cyc;
      int         spk;
      int         led;
      logic       shut;
   } pbb_row_t;
   // Slot is 20 cycles, tone halves 15/13/9. Thermal tones keep their
   // count across each switch, so the eight tones give 5, 3, 4, 3, 5,
   // 3, 4 and 3 speaker rises, 30 in all.
   pbb_row_t   rows [6] = '{'{5'h00, 200, 0, 0, 1'b0},
      '{5'h01, 200, 1, 0, 1'b0}, '{5'h02, 350, 0, 4, 1'b0},
      '{5'h04, 1540, 12, 6, 1'b0}, '{5'h08, 1300, 18, 6, 1'b0},
      '{5'h10, 700, 30, 16, 1'b1}};
   pbb_row_t   r;
   logic       clock = 1'b0;
   logic       rst = 1'b1;
   logic       clear = 1'b1;
   logic [4:0] pins = 5'h00;
   logic       speaker;
   logic       led;
   logic       shut;
   int         spk_n;
   int         led_n;
   int         bad_count = 0;
   int         checks_done = 0;
   int         cycles = 0;

   pbb_seq #(
      .QUARTER_CYC   (20),
      .BEEP_HALF_CYC (15),
      .LOW_HALF_CYC  (13),
      .HIGH_HALF_CYC (9)
   ) dut_u (
      .CLOCK        (clock),
      .RST          (rst),
      .PROMPT       (pins[0]),
      .UPDATE       (pins[1]),
      .VIDEO_ERR    (pins[2]),
      .MEM_ERR      (pins[3]),
      .THERM_WARN   (pins[4]),
      .SPEAKER      (speaker),
      .LED          (led),
      .SHUTDOWN_REQ (shut)
   );
   pbb_panel panel_u (
      .clk       (clock),
      .clear     (clear),
      .spk       (speaker),
      .led       (led),
      .spk_rises (spk_n),
      .led_rises (led_n)
   );

   // A 50 MHz clock.
   always #10 clock = ~clock;

   // Cycle ceiling: a hang counts as a mismatch and ends the run.
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == LIMIT) begin
         bad_count++;
         stop_test();
      end
   end

   task automatic chk_num(input string name, input int exp, input int got);
      checks_done++;
      if (got != exp) begin
         $display("Error %s expected %0d seen %0d", name, exp, got);
         bad_count++;
      end
   endtask

   task automatic chk_bit(input string name, input logic exp, input logic got);
      checks_done++;
      if (got !== exp) begin
         $display("Error %s expected %b seen %b", name, exp, got);
         bad_count++;
      end
   endtask

   // Short reset with all pins low; clears latched indications.
   task automatic restart();
      @(posedge clock);
      rst  <= 1'b1;
      pins <= 5'h00;
      repeat (2) @(posedge clock);
      rst <= 1'b0;
   endtask

   // Applies a pin set and counts panel edges over n cycles.
   task automatic run(input logic [4:0] p, input int n);
      @(posedge clock);
      pins  <= p;
      clear <= 1'b1;
      @(posedge clock);
      clear <= 1'b0;
      repeat (n) @(posedge clock);
   endtask

   task automatic stop_test();
      $display("checks %0d errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         r = rows[i];
         restart();
         run(r.pins, r.cyc);
         chk_num("spk", r.spk, spk_n);
         chk_num("led", r.led, led_n);
         chk_bit("shut", r.shut, shut);
      end
      // Thermal has latched; a later memory error must not break in.
      run(5'h08, 200);
      chk_num("spk", 0, spk_n);
      chk_bit("shut", 1'b1, shut);
      // Video outranks update, so the first beep sounds at once.
      restart();
      run(5'h06, 100);
      chk_num("spk", 3, spk_n);
      // Memory arrives after the first video beep and takes over both outputs.
      restart();
      run(5'h04, 100);
      run(5'h0c, 500);
      chk_num("led", 3, led_n);
      chk_num("spk", 9, spk_n);
      // Reset while latched silences everything.
      @(posedge clock);
      rst <= 1'b1;
      repeat (2) @(posedge clock);
      @(negedge clock);
      chk_bit("speaker", 1'b0, speaker);
      chk_bit("led", 1'b0, led);
      stop_test();
   end
endmodule
